// file: verilog/cpc_param_channel.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// RULE1: Signature: code top nibble, reserved, slot low byte
// RULE2: Master codes: 0 none, 1,2,3,10 requests
// RULE3: Read answers 1, 2 or 11 by size
// RULE4: Write echoes value with 1, 2 or 11
// RULE5: Failed request answers code 7
// RULE6: Own code in reply; 0 while request 0
// RULE7: Master repeats request until it sees reply
// RULE8: Reply held until master's next request
// RULE9: Master closes exchange with code zero
// RULE10: Byte octet 8, word 7-8, dword 5-8
// RULE11: Error code INT16 in octets 7-8
// RULE12: Error codes 0..7 as listed
// RULE13: Error codes 10..19 as listed
// RULE14: Codes 201, 202; 8, 9, 16, 20-100 unused
// RULE15: Works with no output data at all
// RULE16: One request, one reply per telegram
// RULE17: Channel is first eight octets both ways
// RULE18: Ignore reserved bits; run repeats once
// RULE19: Unknown code answers 7 with error 18; while the channel is disabled the code answers error 17 instead
module cpc_param_channel (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB register port
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Parameter channel, octet 0 in bits 63:56
  input  wire logic        tel_valid,
  input  wire logic [63:0] out_chan,
  output logic      [63:0] in_chan,
  // Interrupt
  output logic             irq
);

  cpc_req_if bus ();
  cpc_pkg::cpc_state_t state;

  logic [3:0]  rx_code;
  logic [7:0]  rx_slot;
  logic [7:0]  rx_idx;
  logic [31:0] rx_val;
  logic        close_now;
  logic        open_now;
  logic        accept;
  logic        refuse;
  logic        finish;
  logic [1:0]  ans_sz;
  logic [63:0] ans_word;
  logic [63:0] refuse_word;

  // ==========================================================================
  // Register file and interrupt
  cpc_regs u_regs (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .irq     (irq),
    .bus     (bus.regs)
  );

  // ==========================================================================
  // Helpers
  function automatic logic is_request(input logic [3:0] c);
    return c == cpc_pkg::REQ_READ || c == cpc_pkg::REQ_WR_WORD ||
           c == cpc_pkg::REQ_WR_DWORD || c == cpc_pkg::REQ_WR_BYTE; // see RULE2
  endfunction

  // Size implied by a write code
  function automatic logic [1:0] wr_size(input logic [3:0] c);
    if (c == cpc_pkg::REQ_WR_BYTE) return cpc_pkg::SZ_BYTE;
    if (c == cpc_pkg::REQ_WR_WORD) return cpc_pkg::SZ_WORD;
    return cpc_pkg::SZ_DWORD;
  endfunction

  // Response code for a good answer of a given size
  function automatic logic [3:0] size_code(input logic [1:0] sz);
    if (sz == cpc_pkg::SZ_BYTE) return cpc_pkg::RSP_BYTE; // see RULE3 see RULE4
    if (sz == cpc_pkg::SZ_WORD) return cpc_pkg::RSP_WORD;
    return cpc_pkg::RSP_DWORD;
  endfunction

  // Right-justify the value so it ends in the last octet
  function automatic logic [31:0] fit(input logic [31:0] v, input logic [1:0] sz);
    if (sz == cpc_pkg::SZ_BYTE) return {24'h0, v[7:0]}; // see RULE10
    if (sz == cpc_pkg::SZ_WORD) return {16'h0, v[15:0]};
    return v;
  endfunction

  // Only documented codes reach the master; anything else becomes other error
  function automatic logic err_known(input logic [15:0] e);
    return e <= cpc_pkg::ERR_DESC_FIXED || // see RULE12
           (e >= cpc_pkg::ERR_ACCESS_GRP && e <= cpc_pkg::ERR_CYCLIC_DATA &&
            e != cpc_pkg::ERR_RSVD16) || // see RULE13
           e == cpc_pkg::ERR_ALREADY || e == cpc_pkg::ERR_CONFLICT; // see RULE14
  endfunction

  // Assemble the eight reply octets; reserved nibble and octet stay zero
  function automatic logic [63:0] pack(input logic [3:0] code, input logic [7:0] slot,
                                       input logic [7:0] idx, input logic [31:0] val);
    return {code, 4'h0, slot, idx, 8'h00, val}; // see RULE1 see RULE17
  endfunction

  // ==========================================================================
  // Decode of the incoming channel; reserved bits never looked at
  assign rx_code = out_chan[cpc_pkg::CODE_LSB +: 4]; // see RULE1 see RULE18
  assign rx_slot = out_chan[cpc_pkg::SLOT_LSB +: 8];
  assign rx_idx  = out_chan[cpc_pkg::IDX_LSB +: 8];
  assign rx_val  = out_chan[31:0];

  // One request per telegram; only a finished answer moves without a telegram
  assign close_now = tel_valid && rx_code == cpc_pkg::REQ_NONE; // see RULE9
  assign open_now  = tel_valid && rx_code != cpc_pkg::REQ_NONE &&
                     state == cpc_pkg::ST_IDLE; // see RULE16 see RULE15
  assign accept    = open_now && is_request(rx_code) && bus.enable;
  assign refuse    = open_now && !accept;
  assign finish    = !tel_valid && state == cpc_pkg::ST_BUSY && bus.ans_done;

  // Unknown codes get other error; a disabled channel reports bad state
  assign refuse_word = pack(cpc_pkg::RSP_ERR, rx_slot, rx_idx,
                            {16'h0, bus.enable ? cpc_pkg::ERR_OTHER
                                               : cpc_pkg::ERR_BAD_STATE}); // see RULE19

  // Build the reply from the software answer
  always_comb begin
    ans_sz = (bus.req_code == cpc_pkg::REQ_READ) ? bus.ans_size : wr_size(bus.req_code);
    if (bus.ans_err) begin
      ans_word = pack(cpc_pkg::RSP_ERR, bus.req_slot, bus.req_idx,
                      {16'h0, err_known(bus.ans_code) ? bus.ans_code
                                                      : cpc_pkg::ERR_OTHER}); // see RULE11
    end else if (ans_sz == cpc_pkg::SZ_BAD) begin
      ans_word = pack(cpc_pkg::RSP_ERR, bus.req_slot, bus.req_idx,
                      {16'h0, cpc_pkg::ERR_DATA_TYPE}); // see RULE5
    end else begin
      ans_word = pack(size_code(ans_sz), bus.req_slot, bus.req_idx,
                      fit(bus.req_code == cpc_pkg::REQ_READ ? bus.ans_value
                                                            : bus.req_val, ans_sz));
    end
  end

  // ==========================================================================
  // Exchange state; repeats of the open request are not re-executed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cpc_pkg::ST_IDLE;
    end else begin
      unique case (state)
        cpc_pkg::ST_IDLE: begin
          if (accept) state <= cpc_pkg::ST_BUSY;
          else if (refuse) state <= cpc_pkg::ST_HELD;
        end
        cpc_pkg::ST_BUSY: begin
          if (close_now) state <= cpc_pkg::ST_IDLE; // Master withdrew the request
          else if (finish) state <= cpc_pkg::ST_HELD; // see RULE18
        end
        cpc_pkg::ST_HELD: begin
          if (close_now) state <= cpc_pkg::ST_IDLE; // see RULE9
        end
        default: state <= cpc_pkg::ST_IDLE;
      endcase
    end
  end

  // Latch the accepted request for software and for the echo
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.req_code <= cpc_pkg::REQ_NONE;
      bus.req_slot <= 8'h00;
      bus.req_idx  <= 8'h00;
      bus.req_val  <= 32'h0;
    end else if (accept) begin
      bus.req_code <= rx_code;
      bus.req_slot <= rx_slot;
      bus.req_idx  <= rx_idx;
      bus.req_val  <= rx_val;
    end
  end

  // Outgoing channel; held between events so every telegram repeats it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_chan <= 64'h0;
    end else if (close_now) begin
      in_chan <= 64'h0; // see RULE6
    end else if (refuse) begin
      in_chan <= refuse_word; // see RULE5
    end else if (finish) begin
      in_chan <= ans_word; // see RULE8
    end
  end

  // Event pulses for the status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.ev_post   <= 1'b0;
      bus.ev_close  <= 1'b0;
      bus.ev_refuse <= 1'b0;
    end else begin
      bus.ev_post   <= accept;
      bus.ev_close  <= close_now && state != cpc_pkg::ST_IDLE;
      bus.ev_refuse <= refuse;
    end
  end

  assign bus.req_valid = state == cpc_pkg::ST_BUSY;
  assign bus.state     = state;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_idle_no_reply: assert property ( // see RULE6
    state == cpc_pkg::ST_IDLE |-> in_chan == 64'h0)
    else $error("Reply present while idle");

  a_zero_closes: assert property ( // see RULE9
    close_now |=> state == cpc_pkg::ST_IDLE && in_chan[63:60] == cpc_pkg::RSP_NONE)
    else $error("Zero request did not close the exchange");

  a_reply_held: assert property ( // see RULE8
    state == cpc_pkg::ST_HELD && !close_now |=> $stable(in_chan))
    else $error("Held reply changed");

  a_bad_code: assert property ( // see RULE19
    open_now && !is_request(rx_code) && bus.enable |=>
      in_chan[63:60] == cpc_pkg::RSP_ERR && in_chan[15:0] == cpc_pkg::ERR_OTHER)
    else $error("Unknown code not answered with error 18");

  a_byte_echo: assert property ( // see RULE4
    finish && !bus.ans_err && bus.req_code == cpc_pkg::REQ_WR_BYTE |=>
      in_chan[63:60] == cpc_pkg::RSP_BYTE && in_chan[31:8] == 24'h0 &&
      in_chan[7:0] == bus.req_val[7:0])
    else $error("Byte write not echoed in last octet");

  a_read_dword: assert property ( // see RULE3
    finish && !bus.ans_err && bus.req_code == cpc_pkg::REQ_READ &&
    bus.ans_size == cpc_pkg::SZ_DWORD |=>
      in_chan[63:60] == cpc_pkg::RSP_DWORD && in_chan[31:0] == $past(bus.ans_value))
    else $error("Double-word read reply wrong");

  a_err_octets: assert property ( // see RULE11
    finish && bus.ans_err |=> in_chan[63:60] == cpc_pkg::RSP_ERR &&
      in_chan[31:16] == 16'h0 && err_known(in_chan[15:0]))
    else $error("Error reply malformed");

  a_run_once: assert property ( // see RULE18
    bus.ev_post |-> !$past(bus.ev_post) ##1 !bus.ev_post)
    else $error("Request executed twice");

  a_silent_master: assert property ( // see RULE15
    !tel_valid && !finish |=> $stable(state) && $stable(in_chan))
    else $error("Channel moved without a telegram");

  a_reserved_zero: assert property ( // see RULE1
    state == cpc_pkg::ST_HELD |-> in_chan[59:56] == 4'h0 && in_chan[39:32] == 8'h0)
    else $error("Reserved reply bits not zero");

  a_refuse_reply: assert property ( // see RULE5
    refuse |=> in_chan[63:60] == cpc_pkg::RSP_ERR && in_chan[31:16] == 16'h0)
    else $error("Refused request not answered with code 7");

  a_word_echo: assert property ( // see RULE4
    finish && !bus.ans_err && bus.req_code == cpc_pkg::REQ_WR_WORD |=>
      in_chan[63:60] == cpc_pkg::RSP_WORD && in_chan[31:0] == {16'h0, bus.req_val[15:0]})
    else $error("Word write not echoed in last two octets");

  a_dword_echo: assert property ( // see RULE4
    finish && !bus.ans_err && bus.req_code == cpc_pkg::REQ_WR_DWORD |=>
      in_chan[63:60] == cpc_pkg::RSP_DWORD && in_chan[31:0] == bus.req_val)
    else $error("Double-word write not echoed");

  a_slot_echo: assert property ( // see RULE1
    finish |=> in_chan[55:40] == {bus.req_slot, bus.req_idx})
    else $error("Reply slot or index wrong");

  a_repeat_ignored: assert property ( // see RULE18
    tel_valid && rx_code != cpc_pkg::REQ_NONE && state != cpc_pkg::ST_IDLE |=>
      $stable(state) && $stable(in_chan))
    else $error("Repeated request was executed again");

  cp_disabled: cover property (refuse && !bus.enable);
  cp_read_done: cover property (finish && bus.req_code == cpc_pkg::REQ_READ);
  cp_write_done: cover property (finish && bus.req_code == cpc_pkg::REQ_WR_WORD);
  cp_refused: cover property (refuse);
  cp_abort: cover property (close_now && state == cpc_pkg::ST_BUSY);

endmodule // cpc_param_channel
`default_nettype wire

// file: inc/cpc_pkg.sv
`default_nettype none
package cpc_pkg;

  // ==========================================================================
  // Request and response codes
  localparam logic [3:0] REQ_NONE     = 4'h0;
  localparam logic [3:0] REQ_READ     = 4'h1;
  localparam logic [3:0] REQ_WR_WORD  = 4'h2;
  localparam logic [3:0] REQ_WR_DWORD = 4'h3;
  localparam logic [3:0] REQ_WR_BYTE  = 4'ha;
  localparam logic [3:0] RSP_NONE     = 4'h0;
  localparam logic [3:0] RSP_WORD     = 4'h1;
  localparam logic [3:0] RSP_DWORD    = 4'h2;
  localparam logic [3:0] RSP_ERR      = 4'h7;
  localparam logic [3:0] RSP_BYTE     = 4'hb;

  // ==========================================================================
  // Error codes carried as INT16 in the last two octets
  localparam logic [15:0] ERR_UNDEF_SLOT = 16'h0000, ERR_READ_ONLY = 16'h0001,
    ERR_RANGE = 16'h0002, ERR_SUBINDEX = 16'h0003, ERR_NO_ARRAY = 16'h0004,
    ERR_DATA_TYPE = 16'h0005, ERR_RESET_ONLY = 16'h0006, ERR_DESC_FIXED = 16'h0007,
    ERR_ACCESS_GRP = 16'h000a, ERR_NO_AUTH = 16'h000b, ERR_PASSWORD = 16'h000c,
    ERR_TEXT = 16'h000d, ERR_NAME = 16'h000e, ERR_NO_TEXT_ARR = 16'h000f,
    ERR_RSVD16 = 16'h0010, ERR_BAD_STATE = 16'h0011, ERR_OTHER = 16'h0012,
    ERR_CYCLIC_DATA = 16'h0013, ERR_ALREADY = 16'h00c9, ERR_CONFLICT = 16'h00ca;

  // ==========================================================================
  // Value sizes and channel field positions (octet 0 in bits 63:56)
  localparam logic [1:0] SZ_BYTE  = 2'h0;
  localparam logic [1:0] SZ_WORD  = 2'h1;
  localparam logic [1:0] SZ_DWORD = 2'h2;
  localparam logic [1:0] SZ_BAD   = 2'h3;
  localparam int CODE_LSB = 60;
  localparam int SLOT_LSB = 48;
  localparam int IDX_LSB  = 40;

  // ==========================================================================
  // Register map, status bits and reset values
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_MASK    = 8'h08;
  localparam logic [7:0] REG_REQ     = 8'h0c;
  localparam logic [7:0] REG_REQ_VAL = 8'h10;
  localparam logic [7:0] REG_ANS_VAL = 8'h14;
  localparam logic [7:0] REG_ANS     = 8'h18;
  localparam logic [7:0] REG_STATE   = 8'h1c;
  localparam int ST_POST_BIT = 0;
  localparam int ST_CLOSE_BIT = 1;
  localparam int ST_REFUSE_BIT = 2;
  localparam int ANS_ERR_BIT = 31;
  localparam int ANS_SIZE_LSB = 28;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;

  // Exchange state of the channel engine
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_HELD = 2'b10
  } cpc_state_t;

endpackage
`default_nettype wire

// file: inc/cpc_req_if.sv
`timescale 1ns/1ns
`default_nettype none
// Engine to register file: pending request, answer from software, events
interface cpc_req_if;
  logic                req_valid;
  logic [3:0]          req_code;
  logic [7:0]          req_slot;
  logic [7:0]          req_idx;
  logic [31:0]         req_val;
  cpc_pkg::cpc_state_t state;
  logic                ev_post;
  logic                ev_close;
  logic                ev_refuse;
  logic                enable;
  logic                ans_done;
  logic                ans_err;
  logic [1:0]          ans_size;
  logic [15:0]         ans_code;
  logic [31:0]         ans_value;
  modport engine (output req_valid, req_code, req_slot, req_idx, req_val, state,
                  ev_post, ev_close, ev_refuse,
                  input enable, ans_done, ans_err, ans_size, ans_code, ans_value);
  modport regs (input req_valid, req_code, req_slot, req_idx, req_val, state,
                ev_post, ev_close, ev_refuse,
                output enable, ans_done, ans_err, ans_size, ans_code, ans_value);
endinterface
`default_nettype wire

// file: verilog/cpc_regs.sv
`timescale 1ns/1ns
`default_nettype none
module cpc_regs (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt and engine side
  output logic             irq,
  cpc_req_if.regs          bus
);

  logic [31:0] ctrl;
  logic [31:0] mask;
  logic [31:0] ans_val;
  logic [2:0]  status;
  logic [31:0] rdata;
  logic        hit;
  logic        wr;
  logic [2:0]  w1c;

  // ==========================================================================
  // Bus timing: one wait state, write lands when pready is seen high
  assign wr = psel && penable && pready && pwrite;
  assign w1c = (wr && paddr == cpc_pkg::REG_STATUS) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata  <= pwrite ? 32'h0 : rdata;
        pslverr <= !hit; // Unmapped offsets answer with an error
      end
    end
  end

  // Read decode
  always_comb begin
    hit   = 1'b1;
    rdata = 32'h0;
    unique case (paddr)
      cpc_pkg::REG_CTRL:    rdata = ctrl;
      cpc_pkg::REG_STATUS:  rdata = {29'h0, status};
      cpc_pkg::REG_MASK:    rdata = mask;
      cpc_pkg::REG_REQ:     rdata = {bus.req_code, 4'h0, bus.req_slot, bus.req_idx,
                                     7'h0, bus.req_valid};
      cpc_pkg::REG_REQ_VAL: rdata = bus.req_val;
      cpc_pkg::REG_ANS_VAL: rdata = ans_val;
      cpc_pkg::REG_ANS:     rdata = 32'h0;
      cpc_pkg::REG_STATE:   rdata = {30'h0, bus.state};
      default:              hit = 1'b0;
    endcase
  end

  // Plain read/write registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= cpc_pkg::CTRL_RESET;
      mask    <= cpc_pkg::MASK_RESET;
      ans_val <= 32'h0;
    end else if (wr) begin
      if (paddr == cpc_pkg::REG_CTRL) ctrl <= pwdata;
      if (paddr == cpc_pkg::REG_MASK) mask <= pwdata;
      if (paddr == cpc_pkg::REG_ANS_VAL) ans_val <= pwdata;
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 3'h0;
      irq    <= 1'b0;
    end else begin
      status <= (status & ~w1c) | {bus.ev_refuse, bus.ev_close, bus.ev_post};
      irq    <= |(status & mask[2:0]);
    end
  end

  // Writing the answer register hands the result to the engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.ans_done <= 1'b0;
      bus.ans_err  <= 1'b0;
      bus.ans_size <= cpc_pkg::SZ_BYTE;
      bus.ans_code <= 16'h0;
    end else begin
      bus.ans_done <= wr && paddr == cpc_pkg::REG_ANS;
      if (wr && paddr == cpc_pkg::REG_ANS) begin
        bus.ans_err  <= pwdata[cpc_pkg::ANS_ERR_BIT];
        bus.ans_size <= pwdata[cpc_pkg::ANS_SIZE_LSB +: 2];
        bus.ans_code <= pwdata[15:0];
      end
    end
  end

  assign bus.enable    = ctrl[0];
  assign bus.ans_value = ans_val;

endmodule // cpc_regs
`default_nettype wire

// file: tb/cpc_master_model.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================================
// Cyclic master: one telegram every five cycles, repeats, then closes
module cpc_master_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control from the bench
  input  wire logic        start,
  input  wire logic [63:0] req,
  output logic             done,
  output logic      [63:0] reply_first,
  output logic      [63:0] reply_last,
  // Telegram link
  output logic             tel_valid,
  output logic      [63:0] out_chan,
  input  wire logic [63:0] in_chan
);
  logic       active;
  logic       seen;
  logic [2:0] cnt;
  logic [1:0] left;

  // Two repeats after the reply test that the answer is held, not rerun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tel_valid <= 1'b0;
      out_chan <= 64'h0;
      {active, seen, done, cnt, left} <= '0;
      reply_first <= 64'h0;
      reply_last <= 64'h0;
    end else if (start) begin
      {active, seen, done, cnt} <= {1'b1, 1'b0, 1'b0, 3'h0};
      left <= 2'h2;
      tel_valid <= 1'b0;
      out_chan <= ~out_chan;
    end else if (active && cnt == 3'h0) begin
      cnt <= 3'h1;
      tel_valid <= 1'b1;
      if (seen && left == 2'h0) begin
        out_chan <= {4'h0, req[59:0]};
        active <= 1'b0;
        done <= 1'b1;
        reply_last <= in_chan;
      end else begin
        out_chan <= req;
        if (seen) left <= left - 2'h1;
      end
    end else begin
      // Between telegrams tel_valid is low and out_chan toggles, showing stale and inverted data
      tel_valid <= 1'b0;
      out_chan <= ~out_chan;
      if (active) cnt <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
      if (active && !seen && in_chan[63:60] != 4'h0) begin
        seen <= 1'b1;
        reply_first <= in_chan;
      end
    end
  end
endmodule // cpc_master_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {
    logic [63:0] req;
    logic [31:0] ans;
    logic [31:0] aval;
    logic [3:0]  code;
    logic [31:0] val;
  } cpc_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        tel_valid, start, done;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, v;
  logic [63:0] out_chan, in_chan, req, reply_first, reply_last;
  logic        e;
  int          n_mismatch, n_tests, i;
  // Reserved bits are set in every request; the reply must not echo them
  cpc_row_t rows [13] = '{
    '{64'h1f03_10ff_0000_0000, 32'h1000_0000, 32'h0000_1234, 4'h1, 32'h0000_1234},
    '{64'h1f01_11ff_0000_0000, 32'h2000_0000, 32'hdead_beef, 4'h2, 32'hdead_beef},
    '{64'h1f02_12ff_0000_0000, 32'h0000_0000, 32'h0000_00a5, 4'hb, 32'h0000_00a5},
    '{64'h2f04_13ff_aaaa_5678, 32'h1000_0000, 32'h0, 4'h1, 32'h0000_5678},
    '{64'h3f05_14ff_1234_5678, 32'h2000_0000, 32'h0, 4'h2, 32'h1234_5678},
    '{64'haf00_15ff_5555_55c3, 32'h0000_0000, 32'h0, 4'hb, 32'h0000_00c3},
    '{64'h1f03_20ff_0000_0000, 32'h9000_0002, 32'h0, 4'h7, 32'h0000_0002},
    '{64'h1f03_21ff_0000_0000, 32'h8000_0000, 32'h0, 4'h7, 32'h0000_0000},
    '{64'h2f03_22ff_0000_0001, 32'h9000_00c9, 32'h0, 4'h7, 32'h0000_00c9},
    '{64'h3f03_23ff_0000_0001, 32'ha000_00ca, 32'h0, 4'h7, 32'h0000_00ca},
    '{64'h1f03_24ff_0000_0000, 32'h9000_0011, 32'h0, 4'h7, 32'h0000_0011},
    '{64'h1f03_25ff_0000_0000, 32'h9000_0008, 32'h0, 4'h7, 32'h0000_0012},
    '{64'h1f03_26ff_0000_0000, 32'h3000_0000, 32'h0, 4'h7, 32'h0000_0005}};

  cpc_param_channel uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tel_valid(tel_valid), .out_chan(out_chan), .in_chan(in_chan),
    .irq(irq));
  cpc_master_model master (.pclk(pclk), .presetn(presetn), .start(start), .req(req),
    .done(done), .reply_first(reply_first), .reply_last(reply_last),
    .tel_valid(tel_valid), .out_chan(out_chan), .in_chan(in_chan));

  // ==========================================================================
  // Helpers
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      n_mismatch++;
    end
  endtask

  // Entered just after an edge; leaves one idle cycle so psel never toggles twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No fixed wait count: only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One exchange; sw says whether software has to answer it
  task automatic do_row(input cpc_row_t r, input logic sw);
    int          k;
    logic [63:0] x;
    x = {r.code, 4'h0, r.req[55:40], 8'h00, r.val};
    req <= r.req;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    @(posedge pclk);
    if (sw) begin
      v = 32'h0;
      for (k = 0; k < 20 && v[0] !== 1'b1; k++) apb(1'b0, cpc_pkg::REG_REQ, 32'h0);
      chk("req", 64'(v), {32'h0, r.req[63:60], 4'h0, r.req[55:40], 8'h01});
      apb(1'b0, cpc_pkg::REG_REQ_VAL, 32'h0);
      chk("req_val", 64'(v), {32'h0, r.req[31:0]});
      chk("busy_reply", in_chan, 64'h0);
      chk("irq_post", 64'(irq), 64'h1);
      apb(1'b1, cpc_pkg::REG_ANS_VAL, r.aval);
      // An answer that meets a telegram edge is dropped, so software retries
      for (k = 0; k < 4 && v !== 32'h2; k++) begin
        apb(1'b1, cpc_pkg::REG_ANS, r.ans);
        apb(1'b0, cpc_pkg::REG_STATE, 32'h0);
      end
    end
    for (k = 0; k < 300 && done !== 1'b1; k++) @(posedge pclk);
    repeat (3) @(posedge pclk);
    chk("reply", reply_first, x);
    chk("reply_held", reply_last, x);
    chk("closed", in_chan, 64'h0);
  endtask

  // ==========================================================================
  // Clock, watchdog and sequence
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    {presetn, psel, penable, pwrite, start, paddr, pwdata, req} = '0;
    {n_mismatch, n_tests} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // No telegrams yet: the register side must still work
    chk("reset_reply", in_chan, 64'h0);
    chk("reset_irq", 64'(irq), 64'h0);
    apb(1'b0, cpc_pkg::REG_CTRL, 32'h0);
    chk("ctrl", 64'(v), 64'(cpc_pkg::CTRL_RESET));
    apb(1'b0, cpc_pkg::REG_MASK, 32'h0);
    chk("mask", 64'(v), 64'(cpc_pkg::MASK_RESET));
    apb(1'b0, cpc_pkg::REG_STATUS, 32'h0);
    chk("status", 64'(v), 64'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {31'h0, e, v}, {31'h0, 1'b1, 32'h0});
    apb(1'b1, cpc_pkg::REG_MASK, 32'h7);
    $display("Test reset finished");
    for (i = 0; i < 13; i++) begin
      do_row(rows[i], 1'b1);
      apb(1'b1, cpc_pkg::REG_STATUS, 32'h7);
      repeat (3) @(posedge pclk);
      chk("irq_clear", 64'(irq), 64'h0);
      $display("Test row %0d finished", i);
    end
    // Unknown code is refused by hardware, flagged, and masking hides it
    do_row('{64'h5f07_30ff_0000_0000, 32'h0, 32'h0, 4'h7, 32'h0000_0012}, 1'b0);
    apb(1'b0, cpc_pkg::REG_STATUS, 32'h0);
    chk("refused", 64'(v & 32'h4), 64'h4);
    chk("irq_refuse", 64'(irq), 64'h1);
    apb(1'b1, cpc_pkg::REG_MASK, 32'h0);
    repeat (3) @(posedge pclk);
    chk("irq_masked", 64'(irq), 64'h0);
    apb(1'b1, cpc_pkg::REG_MASK, 32'h7);
    apb(1'b1, cpc_pkg::REG_STATUS, 32'h7);
    $display("Test refuse finished");
    // Disabled channel answers every request with an error
    apb(1'b1, cpc_pkg::REG_CTRL, 32'h0);
    do_row('{64'h2f06_31ff_0000_0042, 32'h0, 32'h0, 4'h7, 32'h0000_0011}, 1'b0);
    apb(1'b1, cpc_pkg::REG_CTRL, 32'h1);
    $display("Test disabled finished");
    // Reset in mid-run drops the pending interrupt and restores the mask
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("irq_reset", 64'(irq), 64'h0);
    chk("chan_reset", in_chan, 64'h0);
    apb(1'b0, cpc_pkg::REG_MASK, 32'h0);
    chk("mask_reset", 64'(v), 64'(cpc_pkg::MASK_RESET));
    $display("Test mid reset finished");
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
